// file: rtl/dicm_channel.sv
// One DMA channel's pending bit and interrupt enable bit.
// Assumes all strobes are one-cycle pulses from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module dicm_channel (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic doneEvent,
  input  wire logic clearPending,
  input  wire logic writeMask,
  input  wire logic maskData,
  input  wire logic setEnable,
  input  wire logic clearEnable,
  output var  logic pending,
  output var  logic enable
);

  logic next_pending;
  logic next_enable;

  always_comb begin
    next_pending = pending;
    next_enable  = enable;
    // A completion arriving while software clears is kept.
    if (doneEvent) begin
      next_pending = 1'b1;
    end else if (clearPending) begin
      next_pending = 1'b0;
    end
    if (writeMask) begin
      next_enable = maskData;
    end else if (setEnable) begin
      next_enable = 1'b1;
    end else if (clearEnable) begin
      next_enable = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pending <= dicm_pkg::RST_PENDING[0];
      enable  <= dicm_pkg::RST_ENABLE[0];
    end else begin
      pending <= next_pending;
      enable  <= next_enable;
    end
  end

  AST_PEND_SET: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    doneEvent |=> pending)
    else $error("Pending bit not set after completion event.");

  AST_PEND_CLEAR: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (clearPending && !doneEvent) |=> !pending)
    else $error("Pending bit not cleared by a one written to clear port.");

  AST_PEND_HOLD: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (!clearPending && !doneEvent) |=> (pending == $past(pending)))
    else $error("Pending bit changed without event or clear.");

  AST_EN_WRITE: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    writeMask |=> (enable == $past(maskData)))
    else $error("Enable bit does not follow the mask write.");

  AST_EN_SET: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (setEnable && !writeMask) |=> enable)
    else $error("Enable bit not set by set port.");

  AST_EN_CLEAR: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (clearEnable && !writeMask && !setEnable) |=> !enable)
    else $error("Enable bit not cleared by clear port.");

  AST_EN_HOLD: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (!writeMask && !setEnable && !clearEnable) |=> $stable(enable))
    else $error("Enable bit changed without a write.");

endmodule // dicm_channel

`default_nettype wire

// file: rtl/dicm_irq_mask_clear.sv
// DMA channel interrupt bookkeeping behind an Avalon-MM slave.
// Assumes doneEvent pulses come from the DMA engine on core_clk.
//
// Notes on behaviour
// - Each of channels 0 to 5 keeps a readable pending bit, 1 when set.
// - Writing 1 to a clear-port bit clears that pending bit unless a completion arrives in the same cycle; 0 does nothing.
// - The enable mask bits 0 to 5 are read/write, 1 enables, reset 0.
// - Writing 1 to a set-enable bit sets that enable; zeros change nothing.
// - Writing 1 to a clear-enable bit clears that enable; zeros do nothing.
// - The set-enable and clear-enable ports always read as zero.
// - The status-clear port always reads as zero.
`timescale 1ns/100ps
`default_nettype none

module dicm_irq_mask_clear (
  input  wire logic                          core_clk,
  input  wire logic                          arst_n,
  input  wire logic [dicm_pkg::CHANNELS-1:0] doneEvent,
  input  wire logic [dicm_pkg::ADDR_W-1:0]   address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [dicm_pkg::BE_W-1:0]     byteenable,
  input  wire logic [dicm_pkg::DATA_W-1:0]   writedata,
  output var  logic [dicm_pkg::DATA_W-1:0]   readdata,
  output var  logic                          waitrequest,
  output var  logic                          dmaIrq
);

  logic [dicm_pkg::CHANNELS-1:0] pending;
  logic [dicm_pkg::CHANNELS-1:0] enable;
  logic [dicm_pkg::CHANNELS-1:0] clearPending;
  logic [dicm_pkg::CHANNELS-1:0] setEnable;
  logic [dicm_pkg::CHANNELS-1:0] clearEnable;
  logic [dicm_pkg::CHANNELS-1:0] maskData;
  logic                          writeMask;
  logic                          ackPhase;
  logic                          next_ackPhase;
  logic [dicm_pkg::DATA_W-1:0]   next_readdata;
  logic                          next_dmaIrq;
  logic                          writeTaken;
  logic                          laneOn;

  // Every access takes two edges: the first registers the read data, the
  // second completes it. This trades one cycle for a flopped readdata.
  assign waitrequest = (read || write) && !ackPhase;
  assign writeTaken  = write && ackPhase;
  assign laneOn      = byteenable[dicm_pkg::CH_LANE];

  assign maskData = writedata[dicm_pkg::CH_LSB +: dicm_pkg::CHANNELS];

  always_comb begin
    next_ackPhase = (read || write) && !ackPhase;
    next_readdata = dicm_pkg::READ_ZERO;
    next_dmaIrq   = |(pending & enable);
    clearPending  = '0;
    setEnable     = '0;
    clearEnable   = '0;
    writeMask     = 1'b0;
    if (read && !ackPhase) begin
      case (address)
        dicm_pkg::ADDR_IRQ_STATUS: begin
          next_readdata[dicm_pkg::CH_LSB +: dicm_pkg::CHANNELS] =
            pending;
        end
        dicm_pkg::ADDR_IRQ_ENABLE_MASK: begin
          next_readdata[dicm_pkg::CH_LSB +: dicm_pkg::CHANNELS] =
            enable;
        end
        default: begin
          // Clear, set and clear-enable ports hold no state to show.
          next_readdata = dicm_pkg::READ_ZERO;
        end
      endcase
    end
    if (writeTaken && laneOn) begin
      case (address)
        dicm_pkg::ADDR_IRQ_STATUS_CLEAR: begin
          clearPending = maskData;
        end
        dicm_pkg::ADDR_IRQ_ENABLE_MASK: begin
          writeMask = 1'b1;
        end
        dicm_pkg::ADDR_IRQ_ENABLE_SET: begin
          setEnable = maskData;
        end
        dicm_pkg::ADDR_IRQ_ENABLE_CLEAR: begin
          clearEnable = maskData;
        end
        default: begin
          // Unmapped writes are dropped silently.
          writeMask = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ackPhase <= 1'b0;
      readdata <= dicm_pkg::READ_ZERO;
      dmaIrq   <= 1'b0;
    end else begin
      ackPhase <= next_ackPhase;
      readdata <= next_readdata;
      dmaIrq   <= next_dmaIrq;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < dicm_pkg::CHANNELS; ch++) begin : gChannel
      dicm_channel uChannel (
        .core_clk     (core_clk),
        .arst_n       (arst_n),
        .doneEvent    (doneEvent[ch]),
        .clearPending (clearPending[ch]),
        .writeMask    (writeMask),
        .maskData     (maskData[ch]),
        .setEnable    (setEnable[ch]),
        .clearEnable  (clearEnable[ch]),
        .pending      (pending[ch]),
        .enable       (enable[ch])
      );
    end
  endgenerate

  AST_IRQ_LEVEL: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    ##1 (dmaIrq == $past(|(pending & enable))))
    else $error("Interrupt output disagrees with pending and enable.");

  AST_READ_SETCLR_ZERO: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (read && !waitrequest && (address == dicm_pkg::ADDR_IRQ_ENABLE_SET ||
      address == dicm_pkg::ADDR_IRQ_ENABLE_CLEAR)) |-> (readdata == '0))
    else $error("Set or clear enable port read nonzero.");

  AST_READ_CLEAR_ZERO: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (read && !waitrequest && address == dicm_pkg::ADDR_IRQ_STATUS_CLEAR)
      |-> (readdata == '0))
    else $error("Status clear port read nonzero.");

  AST_READ_MASK: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (read && waitrequest && address == dicm_pkg::ADDR_IRQ_ENABLE_MASK)
      |=> (!waitrequest && readdata[dicm_pkg::CHANNELS-1:0] ==
           $past(enable)))
    else $error("Enable mask read wrong or late.");

  AST_READ_STATUS: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (read && waitrequest && address == dicm_pkg::ADDR_IRQ_STATUS)
      |=> (readdata[dicm_pkg::CHANNELS-1:0] == $past(pending)))
    else $error("Pending status read wrong.");

  // Write checks look at the registers one edge after the accepted beat.
  AST_CLEAR_ONES: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (write && !waitrequest && laneOn &&
      address == dicm_pkg::ADDR_IRQ_STATUS_CLEAR)
      |=> ((pending & $past(maskData)) ==
           ($past(doneEvent) & $past(maskData))))
    else $error("Pending bit survived a one written to the clear port.");

  AST_CLEAR_ZEROS: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (write && !waitrequest && laneOn &&
      address == dicm_pkg::ADDR_IRQ_STATUS_CLEAR)
      |=> ((pending & ~$past(maskData)) ==
           (($past(pending) | $past(doneEvent)) & ~$past(maskData))))
    else $error("Clear port write disturbed a bit written as zero.");

  AST_MASK_WHOLE: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (write && !waitrequest && laneOn &&
      address == dicm_pkg::ADDR_IRQ_ENABLE_MASK)
      |=> (enable == $past(maskData)))
    else $error("Enable mask does not hold the value written.");

  AST_LANE_OFF: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (write && !waitrequest && !laneOn)
      |=> (enable == $past(enable)))
    else $error("Write with lane zero disabled changed the enables.");

  AST_SET_ONES: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (write && !waitrequest && laneOn &&
      address == dicm_pkg::ADDR_IRQ_ENABLE_SET)
      |=> ((enable & $past(maskData)) == $past(maskData)))
    else $error("Set port write left an enable bit low.");

  AST_SET_ZEROS: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (write && !waitrequest && laneOn &&
      address == dicm_pkg::ADDR_IRQ_ENABLE_SET)
      |=> ((enable & ~$past(maskData)) ==
           ($past(enable) & ~$past(maskData))))
    else $error("Set port write disturbed a bit written as zero.");

  AST_ECLR_ONES: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (write && !waitrequest && laneOn &&
      address == dicm_pkg::ADDR_IRQ_ENABLE_CLEAR)
      |=> ((enable & $past(maskData)) == '0))
    else $error("Clear enable write left an enable bit high.");

  AST_ECLR_ZEROS: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (write && !waitrequest && laneOn &&
      address == dicm_pkg::ADDR_IRQ_ENABLE_CLEAR)
      |=> ((enable & ~$past(maskData)) ==
           ($past(enable) & ~$past(maskData))))
    else $error("Clear enable write disturbed a bit written as zero.");

  // The status word is read only, so only completions may move it.
  AST_STATUS_RO: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    (write && !waitrequest && address == dicm_pkg::ADDR_IRQ_STATUS)
      |=> (pending == ($past(pending) | $past(doneEvent))))
    else $error("Write to the status word changed a pending bit.");

endmodule // dicm_irq_mask_clear

`default_nettype wire

// file: rtl/dicm_pkg.sv
// Constants shared by the DMA channel interrupt mask and clear block.
// Assumes a 32-bit Avalon-MM byte address and one 125 MHz system clock.
package dicm_pkg;

  localparam int unsigned CHANNELS = 6;
  localparam int unsigned ADDR_W   = 32;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned BE_W     = 4;

  // Printed byte addresses of the registers.
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS       = 32'h5006_0304;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS_CLEAR = 32'h5006_0308;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE_MASK  = 32'h5006_030c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE_SET   = 32'h5006_0310;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE_CLEAR = 32'h5006_0314;

  // The channel bits sit in byte lane zero.
  localparam int unsigned CH_LSB       = 0;
  localparam int unsigned CH_LANE      = 0;

  localparam logic [CHANNELS-1:0] RST_PENDING = 6'h00;
  localparam logic [CHANNELS-1:0] RST_ENABLE  = 6'h00;
  localparam logic [DATA_W-1:0]   READ_ZERO   = 32'h0000_0000;

endpackage

// file: verif/test_dma_channel_irq_mask_clear.sv
// Self-checking bench for the DMA channel interrupt mask and clear block.
// Assumes the design answers each Avalon access within a few clock cycles.
`timescale 1ns/100ps
`default_nettype none

module test_dma_channel_irq_mask_clear;
  logic        core_clk;
  logic        arst_n;
  logic [5:0]  doneEvent;
  logic [31:0] address;
  logic        read;
  logic        write;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        dmaIrq;
  int          n_mismatch;
  int          tests_run;
  localparam logic [31:0] STS  = dicm_pkg::ADDR_IRQ_STATUS;
  localparam logic [31:0] SCLR = dicm_pkg::ADDR_IRQ_STATUS_CLEAR;
  localparam logic [31:0] MASK = dicm_pkg::ADDR_IRQ_ENABLE_MASK;
  localparam logic [31:0] ESET = dicm_pkg::ADDR_IRQ_ENABLE_SET;
  localparam logic [31:0] ECLR = dicm_pkg::ADDR_IRQ_ENABLE_CLEAR;

  dicm_irq_mask_clear dut_u (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .doneEvent   (doneEvent),
    .address     (address),
    .read        (read),
    .write       (write),
    .byteenable  (byteenable),
    .writedata   (writedata),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .dmaIrq      (dmaIrq)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Called just after a rising edge; the trailing edge keeps an idle cycle
  // so the strobe is never lowered and raised in one time step.
  task automatic access(input logic wr, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    read      <= ~wr;
    write     <= wr;
    address   <= a;
    writedata <= d;
    // Only the watchdog ends a wait that never gets its answer.
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    access(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask

  task automatic irq_is(input logic exp);
    repeat (2) @(posedge core_clk);
    check({31'h0000_0000, dmaIrq}, {31'h0000_0000, exp});
  endtask

  task automatic test_reset;
    rd(STS, 32'h0000_0000);
    rd(MASK, 32'h0000_0000);
    rd(SCLR, 32'h0000_0000);
    rd(ESET, 32'h0000_0000);
    rd(ECLR, 32'h0000_0000);
    irq_is(1'b0);
    $display("test reset done");
  endtask

  task automatic test_pending;
    doneEvent <= 6'h3f;
    @(posedge core_clk);
    doneEvent <= 6'h00;
    repeat (2) @(posedge core_clk);
    rd(STS, 32'h0000_003f);
    wr(SCLR, 32'h0000_0000);
    rd(STS, 32'h0000_003f);
    wr(SCLR, 32'h0000_0005);
    rd(STS, 32'h0000_003a);
    wr(STS, 32'h0000_0000);
    rd(STS, 32'h0000_003a);
    // A completion held across a clear must win.
    doneEvent <= 6'h01;
    wr(SCLR, 32'h0000_0001);
    doneEvent <= 6'h00;
    rd(STS, 32'h0000_003b);
    wr(SCLR, 32'h0000_0001);
    rd(STS, 32'h0000_003a);
    rd(SCLR, 32'h0000_0000);
    rd(32'h5006_0300, 32'h0000_0000);
    $display("test pending done");
  endtask

  task automatic test_mask;
    wr(MASK, 32'h0000_002a);
    rd(MASK, 32'h0000_002a);
    byteenable <= 4'he;
    wr(MASK, 32'h0000_003f);
    byteenable <= 4'hf;
    rd(MASK, 32'h0000_002a);
    wr(ESET, 32'h0000_0001);
    rd(MASK, 32'h0000_002b);
    rd(ESET, 32'h0000_0000);
    wr(ECLR, 32'h0000_000a);
    rd(MASK, 32'h0000_0021);
    rd(ECLR, 32'h0000_0000);
    wr(MASK, 32'h0000_0014);
    rd(MASK, 32'h0000_0014);
    wr(MASK, 32'h0000_0021);
    rd(MASK, 32'h0000_0021);
    $display("test mask done");
  endtask

  // Pending 3a with enables 21 overlap only on channel 5.
  task automatic test_irq;
    irq_is(1'b1);
    wr(SCLR, 32'h0000_0020);
    irq_is(1'b0);
    wr(ESET, 32'h0000_0002);
    irq_is(1'b1);
    wr(ECLR, 32'h0000_0002);
    irq_is(1'b0);
    $display("test irq done");
  endtask

  // A reset in mid-run must drop every pending and enable bit.
  task automatic test_rearm;
    wr(ESET, 32'h0000_001a);
    irq_is(1'b1);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    irq_is(1'b0);
    rd(STS, 32'h0000_0000);
    rd(MASK, 32'h0000_0000);
    $display("test rearm done");
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    n_mismatch = 0;
    tests_run  = 0;
    arst_n     = 1'b0;
    doneEvent  = 6'h00;
    address    = 32'h0000_0000;
    read       = 1'b0;
    write      = 1'b0;
    byteenable = 4'hf;
    writedata  = 32'h0000_0000;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    test_reset();
    test_pending();
    test_mask();
    test_irq();
    test_rearm();
    end_of_test();
  end
endmodule // test_dma_channel_irq_mask_clear

`default_nettype wire
